// [utx_pkg.sv]
/*
 Constants and types for one serial transmit channel with its baud
 generator and ready/interrupt pin logic.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package utx_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 128;
	localparam int CNT_W = 8;
	localparam int DIV_W = 16;
	// Prescaler terminal counts for divide by 1 and by 4
	localparam logic [1:0] PRE_LAST_DIV1 = 2'h0;
	localparam logic [1:0] PRE_LAST_DIV4 = 2'h3;
	// Sixteen sample clocks per bit
	localparam logic [3:0] OVS_LAST = 4'hF;
	// Fewest data bits is five; index of the last one
	localparam logic [2:0] DBITS_MIN_LAST = 3'h4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_FULL = 8'h80;
	localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
	localparam logic MARK = 1'b1;
	localparam logic SPACE = 1'b0;

	typedef enum logic [2:0] {
		UTX_IDLE = 3'b000,
		UTX_START = 3'b001,
		UTX_DATA = 3'b010,
		UTX_PARITY = 3'b011,
		UTX_STOP = 3'b100
	} utx_state_type;
endpackage

// [utx_channel.sv]
/*
 Transmit channel: buffer FIFO, prescaler and baud generator, serial
 framer, status flags and the interrupt and ready pins.
 Assumes the host write strobe, configuration and receiver status inputs
 are produced by logic on ref_clk_in.
*/
// Behaviour
// - FIFO off: tx irq low while byte held; high on holding or all empty
// - FIFO on: tx irq low above trigger; high below, empty or tx empty
// - FIFO off: rx irq high once a received byte is held
// - FIFO on: rx irq high above receive trigger, low below
// - Transfer-mode bit picks single-character or block ready behaviour
// - FIFO off: rx ready low with byte; tx ready low when holding empty
// - Single mode: rx ready low while receive FIFO holds a byte
// - Block mode: rx ready falls at trigger or timeout, rises on empty
// - Single mode: tx ready low while transmit FIFO empty
// - Block mode: tx ready low while a free location, high when full
// - Prescaler divides reference clock by 1 or by 4
// - Baud generator divides by 16-bit divisor giving sample clock
// - Each bit lasts sixteen sample clocks
// - Frame is start, data bits, optional parity, stop bits
// - Data goes out least significant bit first after start
// - FIFO on: each write pushes one byte into 128-entry FIFO
// - Holding-empty flag sets when the last byte moves to shift register
// - Transmitter-empty flag sets only after final stop bit
// - Host writes need only the channel clock, no baud activity
`timescale 1ns/1ns

module utx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Filling side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Draining side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out,
	// Fill level
	output logic [$clog2(DEPTH+1)-1:0] count_out
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [$clog2(DEPTH+1)-1:0] count_r;
	logic push;
	logic pop;

	// Handshakes
	assign in_ready_out = (count_r != CW'(DEPTH));
	assign out_valid_out = (count_r != '0);
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_data_out = mem[rd_ptr_r];
	assign count_out = count_r;

	// Storage, no reset needed
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data_in;
		end
	end

	// Pointers wrap at depth; count tracks both ends
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // utx_fifo

module utx_channel (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// Host write to the holding register
	input wire logic wr_valid_in,
	input wire logic [utx_pkg::DATA_W-1:0] wr_data_in,
	output logic wr_ready_out,
	// Configuration
	input wire logic fifo_en_in,
	input wire logic block_mode_in,
	input wire logic irq_on_tx_empty_in,
	input wire logic prescale_div4_in,
	input wire logic [utx_pkg::DIV_W-1:0] divisor_in,
	input wire logic [1:0] data_bits_in,
	input wire logic parity_en_in,
	input wire logic parity_even_in,
	input wire logic two_stop_in,
	input wire logic [utx_pkg::CNT_W-1:0] tx_trigger_in,
	input wire logic [utx_pkg::CNT_W-1:0] rx_trigger_in,
	// Receiver status
	input wire logic rx_byte_held_in,
	input wire logic [utx_pkg::CNT_W-1:0] rx_count_in,
	input wire logic rx_timeout_in,
	// Serial line and pins
	output logic tx_out,
	output logic tx_irq_out,
	output logic rx_irq_out,
	output logic rx_ready_n_out,
	output logic tx_ready_n_out,
	// Status flags and sample tick
	output logic hold_empty_out,
	output logic shift_empty_out,
	output logic tick16_out
);
	utx_pkg::utx_state_type state_r;
	logic [utx_pkg::DATA_W-1:0] tx_shift_reg;
	logic [utx_pkg::DATA_W-1:0] fifo_data;
	logic [utx_pkg::CNT_W-1:0] tx_count;
	logic [utx_pkg::CNT_W-1:0] cnt_nxt;
	logic wr_ready_nxt;
	logic fifo_valid, fifo_in_ready, wr_accept, pop;
	logic [1:0] pre_cnt_r;
	logic [utx_pkg::DIV_W-1:0] div_cnt_r;
	logic tick_pre, tick16;
	logic [3:0] sub_r;
	logic [2:0] bit_r;
	logic stop2_r, par_bit_r, bit_end;
	logic tx_nxt, tx_irq_nxt, rx_irq_nxt, rx_rdy_nxt, tx_rdy_nxt;

	// Parity over the configured data bits only
	function automatic logic frame_parity(input logic [7:0] d,
		input logic [1:0] nbits, input logic even);
		logic [7:0] mask;
		mask = 8'hFF >> (2'h3 - nbits);
		frame_parity = even ? ^(d & mask) : ~^(d & mask);
	endfunction

	utx_fifo #(.WIDTH(utx_pkg::DATA_W), .DEPTH(utx_pkg::FIFO_DEPTH)) u_fifo (
		.clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.in_valid_in(wr_accept),
		.in_ready_out(fifo_in_ready),
		.in_data_in(wr_data_in),
		.out_valid_out(fifo_valid),
		.out_ready_in(pop),
		.out_data_out(fifo_data),
		.count_out(tx_count)
	);

	// host path clocked only; holding register is one deep when FIFO off
	assign wr_accept = wr_valid_in && wr_ready_out;
	// frame starts on a tick so the start bit is full length
	assign pop = (state_r == utx_pkg::UTX_IDLE) && fifo_valid && tick16;
	// Fill after this edge, so the ready pin can be a register
	assign cnt_nxt = tx_count
		+ {{(utx_pkg::CNT_W-1){1'b0}}, wr_accept && fifo_in_ready}
		- {{(utx_pkg::CNT_W-1){1'b0}}, pop};
	assign wr_ready_nxt = fifo_en_in ? (cnt_nxt != utx_pkg::CNT_FULL)
		: (cnt_nxt == utx_pkg::CNT_ZERO);

	assign tick_pre = prescale_div4_in ? (pre_cnt_r == utx_pkg::PRE_LAST_DIV4)
		: 1'b1;
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pre_cnt_r <= utx_pkg::PRE_LAST_DIV1;
		end else begin
			pre_cnt_r <= tick_pre ? utx_pkg::PRE_LAST_DIV1 : pre_cnt_r + 2'h1;
		end
	end

	// divisor counter; zero behaves as one
	assign tick16 = tick_pre && ((div_cnt_r + utx_pkg::DIV_ONE) >= divisor_in);
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_cnt_r <= '0;
		end else if (tick_pre) begin
			div_cnt_r <= tick16 ? '0 : div_cnt_r + utx_pkg::DIV_ONE;
		end
	end

	// bit ends after sixteen sample clocks
	assign bit_end = tick16 && (sub_r == utx_pkg::OVS_LAST);

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= utx_pkg::UTX_IDLE;
			sub_r <= '0;
			bit_r <= '0;
			stop2_r <= 1'b0;
		end else begin
			if (state_r == utx_pkg::UTX_IDLE) begin
				sub_r <= '0;
			end else if (tick16) begin
				sub_r <= sub_r + 4'h1;
			end
			case (state_r)
				utx_pkg::UTX_IDLE: begin
					bit_r <= '0;
					stop2_r <= 1'b0;
					if (pop) begin
						state_r <= utx_pkg::UTX_START;
					end
				end
				utx_pkg::UTX_START: begin
					if (bit_end) begin
						state_r <= utx_pkg::UTX_DATA;
					end
				end
				utx_pkg::UTX_DATA: begin
					if (bit_end) begin
						bit_r <= bit_r + 3'h1;
						if (bit_r == utx_pkg::DBITS_MIN_LAST + 3'(data_bits_in)) begin
							state_r <= parity_en_in ? utx_pkg::UTX_PARITY
								: utx_pkg::UTX_STOP;
						end
					end
				end
				utx_pkg::UTX_PARITY: begin
					if (bit_end) begin
						state_r <= utx_pkg::UTX_STOP;
					end
				end
				utx_pkg::UTX_STOP: begin
					if (bit_end) begin
						if (two_stop_in && !stop2_r) begin
							stop2_r <= 1'b1;
						end else begin
							state_r <= utx_pkg::UTX_IDLE;
						end
					end
				end
				default: begin
					state_r <= utx_pkg::UTX_IDLE;
				end
			endcase
		end
	end

	// shift register loads on pop, shifts right
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_shift_reg <= '0;
			par_bit_r <= 1'b0;
		end else if (pop) begin
			tx_shift_reg <= fifo_data;
			par_bit_r <= frame_parity(fifo_data, data_bits_in, parity_even_in);
		end else if (state_r == utx_pkg::UTX_DATA && bit_end) begin
			tx_shift_reg <= tx_shift_reg >> 1;
		end
	end

	// Line level per state
	always_comb begin
		case (state_r)
			utx_pkg::UTX_START: tx_nxt = utx_pkg::SPACE;
			utx_pkg::UTX_DATA: tx_nxt = tx_shift_reg[0];
			utx_pkg::UTX_PARITY: tx_nxt = par_bit_r;
			default: tx_nxt = utx_pkg::MARK;
		endcase
	end

	// Pin levels per mode
	always_comb begin
		if (irq_on_tx_empty_in) begin
			tx_irq_nxt = (state_r == utx_pkg::UTX_IDLE) && !fifo_valid;
		end else if (fifo_en_in) begin
			tx_irq_nxt = (tx_count < tx_trigger_in) || !fifo_valid;
		end else begin
			tx_irq_nxt = !fifo_valid;
		end
		rx_irq_nxt = fifo_en_in ? (rx_count_in >= rx_trigger_in) : rx_byte_held_in;
		rx_rdy_nxt = rx_ready_n_out;
		if (!fifo_en_in) begin
			rx_rdy_nxt = !rx_byte_held_in;
		end else if (!block_mode_in) begin
			rx_rdy_nxt = (rx_count_in == utx_pkg::CNT_ZERO);
		end else if (rx_count_in == utx_pkg::CNT_ZERO) begin
			rx_rdy_nxt = 1'b1;
		end else if (rx_count_in >= rx_trigger_in || rx_timeout_in) begin
			rx_rdy_nxt = 1'b0;
		end
		if (fifo_en_in && block_mode_in) begin
			tx_rdy_nxt = (tx_count == utx_pkg::CNT_FULL);
		end else begin
			tx_rdy_nxt = fifo_valid;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_out <= utx_pkg::MARK;
			tx_irq_out <= 1'b1;
			rx_irq_out <= 1'b0;
			rx_ready_n_out <= 1'b1;
			tx_ready_n_out <= 1'b0;
			hold_empty_out <= 1'b1;
			shift_empty_out <= 1'b1;
			tick16_out <= 1'b0;
			wr_ready_out <= 1'b1;
		end else begin
			tx_out <= tx_nxt;
			tx_irq_out <= tx_irq_nxt;
			rx_irq_out <= rx_irq_nxt;
			rx_ready_n_out <= rx_rdy_nxt;
			tx_ready_n_out <= tx_rdy_nxt;
			hold_empty_out <= !fifo_valid;
			shift_empty_out <= (state_r == utx_pkg::UTX_IDLE) && !fifo_valid;
			tick16_out <= tick16;
			wr_ready_out <= wr_ready_nxt;
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_start_bit;
		state_r == utx_pkg::UTX_START;
	endsequence
	sequence s_first_data;
		$rose(state_r == utx_pkg::UTX_DATA);
	endsequence

	property p_idle_mark;
		(state_r == utx_pkg::UTX_IDLE) [*2] |-> tx_out;
	endproperty
	a_idle_mark: assert property (p_idle_mark)
		else $error("line not at mark while idle");

	property p_start_space;
		s_start_bit |=> !tx_out;
	endproperty
	a_start_space: assert property (p_start_space)
		else $error("start bit not space");

	property p_lsb_first;
		s_first_data |=> tx_out == $past(tx_shift_reg[0]);
	endproperty
	a_lsb_first: assert property (p_lsb_first)
		else $error("first data bit not bit 0");

	property p_bit_hold;
		(state_r != utx_pkg::UTX_IDLE && !bit_end) |=> $stable(state_r);
	endproperty
	a_bit_hold: assert property (p_bit_hold)
		else $error("state moved before sixteen ticks");

	property p_hold_empty;
		(pop && !wr_accept && !fifo_en_in) |=> ##1 hold_empty_out;
	endproperty
	a_hold_empty: assert property (p_hold_empty)
		else $error("holding empty flag missed the load");

	property p_shift_empty;
		$rose(shift_empty_out) |-> $past(state_r == utx_pkg::UTX_STOP, 2);
	endproperty
	a_shift_empty: assert property (p_shift_empty)
		else $error("transmitter empty before stop ended");

	property p_tx_full;
		(fifo_en_in && block_mode_in && tx_count == utx_pkg::CNT_FULL)
			|=> tx_ready_n_out;
	endproperty
	a_tx_full: assert property (p_tx_full)
		else $error("tx ready low with FIFO full");

	property p_rx_empty;
		(fifo_en_in && block_mode_in && rx_count_in == utx_pkg::CNT_ZERO)
			|=> rx_ready_n_out;
	endproperty
	a_rx_empty: assert property (p_rx_empty)
		else $error("rx ready low with FIFO empty");

	property p_prescale;
		(tick_pre && prescale_div4_in) [*1] ##1 prescale_div4_in [*3]
			|-> !$past(tick_pre) && !$past(tick_pre, 2);
	endproperty
	a_prescale: assert property (p_prescale)
		else $error("prescaler ticked early");
endmodule // utx_channel

// [utx_line_model.sv]
/*
 Behavioural remote receiver that decodes the serial transmit line.
 Assumes tick_in pulses once per sample clock, sixteen to a bit.
*/
`timescale 1ns/1ns
module utx_line_model (
	// Clock and sample tick
	input wire logic clk_in,
	input wire logic tick_in,
	// Serial line and framing
	input wire logic line_in,
	input wire logic [1:0] data_bits_in,
	input wire logic parity_en_in,
	input wire logic parity_even_in,
	input wire logic two_stop_in,
	// Received character
	output logic [7:0] byte_out,
	output logic ok_out,
	output logic done_out
);
	// Wait a number of sample ticks
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_in iff tick_in === 1'b1);
	endtask

	// Decode one frame per falling edge of the line
	initial begin
		done_out = 1'b0;
		byte_out = 8'h00;
		ok_out = 1'b0;
		forever begin
			@(negedge line_in);
			ticks(8);
			ok_out = (line_in === 1'b0);
			byte_out = 8'h00;
			for (int i = 0; i < 5 + data_bits_in; i++) begin
				ticks(16);
				byte_out[i] = line_in;
			end
			if (parity_en_in) begin
				ticks(16);
				ok_out &= line_in === (^byte_out ^ !parity_even_in);
			end
			ticks(16);
			ok_out &= line_in === 1'b1;
			if (two_stop_in) begin
				ticks(16);
				ok_out &= line_in === 1'b1;
			end
			done_out = 1'b1;
			@(posedge clk_in);
			done_out = 1'b0;
		end
	end
endmodule // utx_line_model

// [utx_channel_bench.sv]
/*
 Self-checking bench for the transmit channel and its pins.
 Assumes the remote receiver model decodes every frame sent.
*/
`timescale 1ns/1ns
module utx_channel_bench;
	// Design inputs
	logic ref_clk_in = 1'b0;
	logic arst_n_in, wr_valid_in, fifo_en_in, block_mode_in;
	logic irq_on_tx_empty_in, prescale_div4_in, parity_en_in;
	logic parity_even_in, two_stop_in, rx_byte_held_in, rx_timeout_in;
	logic [7:0] wr_data_in, tx_trigger_in, rx_trigger_in, rx_count_in;
	logic [15:0] divisor_in;
	logic [1:0] data_bits_in;
	// Design outputs
	logic wr_ready_out, tx_out, tx_irq_out, rx_irq_out, rx_ready_n_out;
	logic tx_ready_n_out, hold_empty_out, shift_empty_out, tick16_out;
	// Model outputs and bookkeeping
	logic [7:0] m_byte;
	logic m_ok, m_done;
	logic [7:0] exq [$];
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	// Receive pin table: {fifo,block,held,timeout}, count, {irq,ready_n}
	logic [11:0] rxv [12] = '{12'h001, 12'h202, 12'h801, 12'h820,
		12'h852, 12'hC01, 12'hC21, 12'hC42, 12'hC20, 12'hC01, 12'hD10,
		12'hC01};

	utx_channel dut (.ref_clk_in, .arst_n_in, .wr_valid_in, .wr_data_in,
		.wr_ready_out, .fifo_en_in, .block_mode_in, .irq_on_tx_empty_in,
		.prescale_div4_in, .divisor_in, .data_bits_in, .parity_en_in,
		.parity_even_in, .two_stop_in, .tx_trigger_in, .rx_trigger_in,
		.rx_byte_held_in, .rx_count_in, .rx_timeout_in, .tx_out,
		.tx_irq_out, .rx_irq_out, .rx_ready_n_out, .tx_ready_n_out,
		.hold_empty_out, .shift_empty_out, .tick16_out);

	utx_line_model remote (.clk_in(ref_clk_in), .tick_in(tick16_out),
		.line_in(tx_out), .data_bits_in, .parity_en_in, .parity_even_in,
		.two_stop_in, .byte_out(m_byte), .ok_out(m_ok), .done_out(m_done));

	// Clock at 20 MHz
	initial begin
		forever #25 ref_clk_in = ~ref_clk_in;
	end

	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic gap(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask

	// Wait until the whole transmitter has gone quiet
	task automatic wait_idle;
		gap(3);
		while (shift_empty_out !== 1'b1) @(negedge ref_clk_in);
	endtask

	// Host write held until taken; keep leaves the request raised
	task automatic send(input logic [7:0] d, input logic keep);
		wr_data_in = d;
		wr_valid_in = 1'b1;
		while (wr_ready_out !== 1'b1) @(negedge ref_clk_in);
		exq.push_back(d & (8'hFF >> (3 - data_bits_in)));
		@(negedge ref_clk_in);
		if (!keep)
			wr_valid_in = 1'b0;
	endtask

	// Every frame the remote decodes is compared at once
	always @(posedge m_done) begin
		chk("byte", {8'h00, m_byte}, {8'h00, exq.pop_front()});
		chk("frame", m_ok, 1'b1);
		chk("shift busy", shift_empty_out, 1'b0);
	end

	// Hang guard
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// Main sequence
	initial begin
		int k, n;
		logic [11:0] v;
		{arst_n_in, wr_valid_in, fifo_en_in, block_mode_in} = 4'h0;
		{irq_on_tx_empty_in, prescale_div4_in, parity_en_in} = 3'h0;
		{parity_even_in, two_stop_in, rx_byte_held_in, rx_timeout_in} = 4'h0;
		wr_data_in = 8'h00;
		tx_trigger_in = 8'h10;
		rx_trigger_in = 8'h04;
		rx_count_in = 8'h00;
		divisor_in = 16'h0001;
		data_bits_in = 2'h3;
		gap(16);
		chk("reset pins", {tx_out, tx_irq_out, rx_irq_out, rx_ready_n_out,
			tx_ready_n_out, hold_empty_out, shift_empty_out}, 7'h6B);
		arst_n_in = 1'b1;
		gap(1);
		// Holding register only, two writes back to back
		send(8'hA5, 1'b1);
		send(8'h3C, 1'b0);
		gap(2);
		chk("tx_ready_n held", tx_ready_n_out, 1'b1);
		chk("tx_irq held", tx_irq_out, 1'b0);
		chk("refused", wr_ready_out, 1'b0);
		irq_on_tx_empty_in = 1'b1;
		while (hold_empty_out !== 1'b1) @(negedge ref_clk_in);
		gap(2);
		chk("tx_irq busy", tx_irq_out, 1'b0);
		chk("tx_ready_n free", tx_ready_n_out, 1'b0);
		chk("start bit", tx_out, 1'b0);
		irq_on_tx_empty_in = 1'b0;
		gap(2);
		chk("tx_irq hold empty", tx_irq_out, 1'b1);
		irq_on_tx_empty_in = 1'b1;
		wait_idle();
		gap(2);
		chk("tx_irq idle", tx_irq_out, 1'b1);
		chk("line idle", tx_out, 1'b1);
		irq_on_tx_empty_in = 1'b0;
		// Data widths, parity modes and stop counts
		for (k = 0; k < 4; k++) begin
			data_bits_in = k[1:0];
			parity_en_in = (k != 0);
			parity_even_in = k[0];
			two_stop_in = k[1];
			send(8'hB5, 1'b0);
			wait_idle();
		end
		{data_bits_in, parity_en_in, two_stop_in} = 4'hC;
		for (k = 0; k < 2; k++) begin
			divisor_in = k ? 16'h0002 : 16'h0003;
			prescale_div4_in = (k == 0);
			send(8'h55, 1'b0);
			while (tx_out !== 1'b0) @(negedge ref_clk_in);
			n = 0;
			while (tx_out === 1'b0) begin
				n++;
				@(negedge ref_clk_in);
			end
			chk("bit length", 16'(n), 16'((prescale_div4_in ? 4 : 1) * 16
				* divisor_in));
			wait_idle();
		end
		divisor_in = 16'h0001;
		prescale_div4_in = 1'b0;
		// Buffer filled until refused, then drained
		fifo_en_in = 1'b1;
		gap(2);
		wr_valid_in = 1'b1;
		n = 0;
		for (k = 0; k < 140; k++) begin
			if (wr_ready_out === 1'b1) begin
				exq.push_back(wr_data_in);
				n++;
			end
			@(negedge ref_clk_in);
			wr_data_in = wr_data_in + 8'h01;
		end
		wr_valid_in = 1'b0;
		chk("accepted", 16'(n), 16'(utx_pkg::FIFO_DEPTH + 1));
		chk("tx_ready_n single", tx_ready_n_out, 1'b1);
		chk("tx_irq above", tx_irq_out, 1'b0);
		block_mode_in = 1'b1;
		gap(2);
		chk("tx_ready_n full", tx_ready_n_out, 1'b1);
		while (wr_ready_out !== 1'b1) @(negedge ref_clk_in);
		gap(2);
		chk("tx_ready_n room", tx_ready_n_out, 1'b0);
		tx_trigger_in = 8'hFF;
		gap(2);
		chk("tx_irq below", tx_irq_out, 1'b1);
		irq_on_tx_empty_in = 1'b1;
		gap(2);
		chk("tx_irq tx busy", tx_irq_out, 1'b0);
		irq_on_tx_empty_in = 1'b0;
		while (hold_empty_out !== 1'b1) @(negedge ref_clk_in);
		gap(2);
		chk("tx_irq empty", tx_irq_out, 1'b1);
		wait_idle();
		block_mode_in = 1'b0;
		gap(2);
		chk("tx_ready_n empty", tx_ready_n_out, 1'b0);
		// Receive interrupt and ready pins across modes
		for (k = 0; k < 12; k++) begin
			v = rxv[k];
			{fifo_en_in, block_mode_in, rx_byte_held_in, rx_timeout_in} = v[11:8];
			rx_count_in = {4'h0, v[7:4]};
			gap(2);
			chk("rx pins", {rx_irq_out, rx_ready_n_out}, v[1:0]);
		end
		chk("frames left", 16'(exq.size()), 16'h0000);
		stop_test();
	end
endmodule // utx_channel_bench
